//--- core/wiper_eeprom_map.svh
// Constants for the two-wire wiper memory: offsets, fields, timings
`ifndef WIPER_EEPROM_MAP_SVH
`define WIPER_EEPROM_MAP_SVH
`define WIDE_POT_WIPER_SETTING_OFS 8'hF8
`define FIRST_NARROW_POT_WIPER_SETTING_OFS 8'hF9
`define SECOND_NARROW_POT_WIPER_SETTING_OFS 8'hFA
`define NARROW_POT_MAX 8'h63
`define NARROW_POT_MASK 8'h7F
`define WIPER_RESET 8'h00
`define DEV_CODE 6'b10_1000
`define PAGE_LSB_BITS 3
`define INTERNAL_WRITE_CYCLE_TIME_US 10
`define CLK_MHZ 125
`define INTERNAL_WRITE_CYCLES (`INTERNAL_WRITE_CYCLE_TIME_US * `CLK_MHZ)
`define SCL_HALF_CYCLES 16'h0138
`endif

//--- core/wiper_eeprom_pkg.sv
// Types shared by both ends of the two-wire wiper memory link
package wiper_eeprom_pkg;
  typedef enum logic [3:0] {
    HIDLE = 4'b0001,
    HSTART = 4'b0010,
    HBITS = 4'b0100,
    HSTOP = 4'b1000
  } host_state_t;
  typedef enum logic [4:0] {
    DIDLE = 5'b00001,
    DADDR = 5'b00010,
    DWRITE = 5'b00100,
    DREAD = 5'b01000,
    DIGNORE = 5'b10000
  } dev_state_t;
endpackage

//--- core/two_wire_if.sv
// Two-wire bus carrier: resolves the open-drain wires from the enables
`timescale 1ns/1ps
interface two_wire_if;
  logic sclOutEn;
  logic sdaHostOutEn;
  logic sdaDevOutEn;
  logic scl;
  logic sda;
  // Enables are active low: low means that party pulls the line low
  assign scl = sclOutEn;
  assign sda = sdaHostOutEn & sdaDevOutEn;
  modport device (input scl, input sda, output sdaDevOutEn);
  modport host (output sclOutEn, output sdaHostOutEn, input scl, input sda);
endinterface

//--- core/two_wire_eeprom_wiper_slave.sv
// Device end: two-wire slave with 256-byte memory and wiper bytes
`timescale 1ns/1ps
`include "wiper_eeprom_map.svh"
module two_wire_eeprom_wiper_slave #(
  parameter int WRITE_CYCLES = `INTERNAL_WRITE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  two_wire_if.device bus,
  input wire logic device_select_pin,
  input wire logic writeProtect,
  output logic [7:0] wideWiper,
  output logic [6:0] firstNarrowWiper,
  output logic [6:0] secondNarrowWiper,
  output logic busyWriting,
  output logic standby
);
  ////////////////////////////////////////////////////////////////////////
  logic sclPrev_reg, sdaPrev_reg;
  wiper_eeprom_pkg::dev_state_t state_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] addr_reg;
  logic haveAddr_reg;
  logic [7:0] mem_reg [256];
  logic [7:0] page_reg [8];
  logic [7:0] pageDirty_reg;
  logic [4:0] pageNum_reg;
  logic [31:0] wrCnt_reg;
  logic sdaOutEn_reg;
  logic ackPhase_reg;
  logic masterNack_reg;
  logic readIsRead_reg;
  logic startSeen, stopSeen, sclRise, sclFall;

  // Edge and condition detection; inputs are synchronous to sys_clk
  assign sclRise = bus.scl & ~sclPrev_reg;
  assign sclFall = ~bus.scl & sclPrev_reg;
  assign startSeen = bus.scl & sclPrev_reg & sdaPrev_reg & ~bus.sda;
  assign stopSeen = bus.scl & sclPrev_reg & ~sdaPrev_reg & bus.sda;
  assign bus.sdaDevOutEn = sdaOutEn_reg;

  // Narrow wipers keep the low seven bits only
  function automatic logic [6:0] narrowOf(input logic [7:0] v);
    narrowOf = v[6:0];
  endfunction

  // Line history
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= bus.scl;
      sdaPrev_reg <= bus.sda;
    end
  end

  // Internal write timer; inputs are ignored while it runs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrCnt_reg <= 32'h0000_0000;
      busyWriting <= 1'b0;
    end else if (busyWriting) begin
      wrCnt_reg <= wrCnt_reg + 32'h0000_0001;
      if (wrCnt_reg >= WRITE_CYCLES - 1) begin
        busyWriting <= 1'b0;
      end
    end else if (stopSeen && state_reg == wiper_eeprom_pkg::DWRITE &&
                 pageDirty_reg != 8'h00 && !writeProtect) begin
      wrCnt_reg <= 32'h0000_0000;
      busyWriting <= 1'b1;
    end
  end

  // Memory array: page commit after stop, only the dirty bytes of the page copied back
  always_ff @(posedge sys_clk) begin
    if (!busyWriting && stopSeen && state_reg == wiper_eeprom_pkg::DWRITE &&
        !writeProtect) begin
      for (int i = 0; i < 8; i++) begin
        if (pageDirty_reg[i]) begin
          mem_reg[{pageNum_reg, i[2:0]}] <= page_reg[i];
        end
      end
    end
  end

  // Wiper outputs follow the committed wiper bytes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wideWiper <= `WIPER_RESET;
      firstNarrowWiper <= 7'h00;
      secondNarrowWiper <= 7'h00;
      standby <= 1'b1;
    end else begin
      wideWiper <= mem_reg[`WIDE_POT_WIPER_SETTING_OFS];
      firstNarrowWiper <=
        narrowOf(mem_reg[`FIRST_NARROW_POT_WIPER_SETTING_OFS]);
      secondNarrowWiper <=
        narrowOf(mem_reg[`SECOND_NARROW_POT_WIPER_SETTING_OFS]);
      standby <= (state_reg == wiper_eeprom_pkg::DIDLE ||
                  state_reg == wiper_eeprom_pkg::DIGNORE) &&
                 !busyWriting;
    end
  end

  // Protocol engine: bits counted on rising clock, driven on falling
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= wiper_eeprom_pkg::DIDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= 8'h00;
      haveAddr_reg <= 1'b0;
      pageDirty_reg <= 8'h00;
      pageNum_reg <= 5'h00;
      sdaOutEn_reg <= 1'b1;
      ackPhase_reg <= 1'b0;
      masterNack_reg <= 1'b0;
      readIsRead_reg <= 1'b0;
    end else if (busyWriting) begin
      state_reg <= wiper_eeprom_pkg::DIDLE;
      sdaOutEn_reg <= 1'b1;
    end else if (startSeen) begin
      state_reg <= wiper_eeprom_pkg::DADDR;
      bitCnt_reg <= 4'h0;
      sdaOutEn_reg <= 1'b1;
      ackPhase_reg <= 1'b0;
    end else if (stopSeen) begin
      state_reg <= wiper_eeprom_pkg::DIDLE;
      sdaOutEn_reg <= 1'b1;
      pageDirty_reg <= 8'h00;
      haveAddr_reg <= 1'b0;
    end else if (sclRise && !ackPhase_reg) begin
      // Outgoing read bytes shift on the falling clock only
      if (state_reg != wiper_eeprom_pkg::DREAD) begin
        shift_reg <= {shift_reg[6:0], bus.sda};
      end
      bitCnt_reg <= bitCnt_reg + 4'h1;
    end else if (sclRise && ackPhase_reg) begin
      masterNack_reg <= bus.sda;
    end else if (sclFall) begin
      case (state_reg)
        wiper_eeprom_pkg::DADDR: begin
          if (ackPhase_reg) begin
            ackPhase_reg <= 1'b0;
            bitCnt_reg <= 4'h0;
            sdaOutEn_reg <= 1'b1;
            if (readIsRead_reg) begin
              state_reg <= wiper_eeprom_pkg::DREAD;
              sdaOutEn_reg <= mem_reg[addr_reg][7];
              shift_reg <= {mem_reg[addr_reg][6:0], 1'b1};
            end else begin
              state_reg <= wiper_eeprom_pkg::DWRITE;
            end
          end else if (bitCnt_reg == 4'h8) begin
            if (shift_reg[7:2] == `DEV_CODE &&
                shift_reg[1] == device_select_pin) begin
              sdaOutEn_reg <= 1'b0;
              ackPhase_reg <= 1'b1;
              readIsRead_reg <= shift_reg[0];
              pageDirty_reg <= 8'h00;
              haveAddr_reg <= 1'b0;
            end else begin
              state_reg <= wiper_eeprom_pkg::DIGNORE;
            end
          end
        end
        wiper_eeprom_pkg::DWRITE: begin
          if (ackPhase_reg) begin
            ackPhase_reg <= 1'b0;
            bitCnt_reg <= 4'h0;
            sdaOutEn_reg <= 1'b1;
          end else if (bitCnt_reg == 4'h8) begin
            sdaOutEn_reg <= 1'b0;
            ackPhase_reg <= 1'b1;
            if (!haveAddr_reg) begin
              addr_reg <= shift_reg;
              pageNum_reg <= shift_reg[7:3];
              haveAddr_reg <= 1'b1;
              for (int i = 0; i < 8; i++) begin
                page_reg[i] <= mem_reg[{shift_reg[7:3], i[2:0]}];
              end
            end else begin
              page_reg[addr_reg[2:0]] <= shift_reg;
              pageDirty_reg[addr_reg[2:0]] <= 1'b1;
              addr_reg <= {addr_reg[7:3], addr_reg[2:0] + 3'h1};
            end
          end
        end
        wiper_eeprom_pkg::DREAD: begin
          if (bitCnt_reg == 4'h8 && !ackPhase_reg) begin
            sdaOutEn_reg <= 1'b1;
            ackPhase_reg <= 1'b1;
            addr_reg <= addr_reg + 8'h01;
          end else if (ackPhase_reg) begin
            ackPhase_reg <= 1'b0;
            bitCnt_reg <= 4'h0;
            if (masterNack_reg) begin
              state_reg <= wiper_eeprom_pkg::DIGNORE;
            end else begin
              sdaOutEn_reg <= mem_reg[addr_reg][7];
              shift_reg <= {mem_reg[addr_reg][6:0], 1'b1};
            end
          end else begin
            sdaOutEn_reg <= shift_reg[7];
            shift_reg <= {shift_reg[6:0], 1'b1};
          end
        end
        default: begin
          sdaOutEn_reg <= 1'b1;
        end
      endcase
    end
  end
endmodule

//--- core/two_wire_master.sv
// Host end: bit-level two-wire master driven by a small command port
`timescale 1ns/1ps
`include "wiper_eeprom_map.svh"
module two_wire_master #(
  parameter logic [15:0] HALF_CYCLES = `SCL_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  two_wire_if.host bus,
  input wire logic cmdValid,
  input wire logic cmdStart,
  input wire logic cmdStop,
  input wire logic [8:0] cmdBits,
  output logic cmdReady,
  output logic [8:0] rxBits,
  output logic rxValid
);
  ////////////////////////////////////////////////////////////////////////
  wiper_eeprom_pkg::host_state_t state_reg;
  logic [15:0] divCnt_reg;
  logic tick;
  logic [1:0] phase_reg;
  logic [3:0] bitIdx_reg;
  logic [8:0] tx_reg;
  logic [8:0] rx_reg;
  logic stopAfter_reg;

  // Quarter-bit enable from a divider
  assign tick = (divCnt_reg == HALF_CYCLES);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_reg <= 16'h0000;
    end else begin
      divCnt_reg <= tick ? 16'h0000 : divCnt_reg + 16'h0001;
    end
  end

  // Optional start, nine bits (eighth then ack slot), optional stop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= wiper_eeprom_pkg::HIDLE;
      bus.sclOutEn <= 1'b1;
      bus.sdaHostOutEn <= 1'b1;
      cmdReady <= 1'b1;
      rxValid <= 1'b0;
      rxBits <= 9'h000;
      phase_reg <= 2'h0;
      bitIdx_reg <= 4'h0;
      tx_reg <= 9'h1FF;
      rx_reg <= 9'h000;
      stopAfter_reg <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      case (state_reg)
        wiper_eeprom_pkg::HIDLE: begin
          if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            tx_reg <= cmdBits;
            stopAfter_reg <= cmdStop;
            bitIdx_reg <= 4'h0;
            phase_reg <= 2'h0;
            state_reg <= cmdStart ? wiper_eeprom_pkg::HSTART
                                  : wiper_eeprom_pkg::HBITS;
          end
        end
        wiper_eeprom_pkg::HSTART: if (tick) begin
          // Release data, raise clock, then pull data low under high clock
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'h0) bus.sdaHostOutEn <= 1'b1;
          if (phase_reg == 2'h1) bus.sclOutEn <= 1'b1;
          if (phase_reg == 2'h2) bus.sdaHostOutEn <= 1'b0;
          if (phase_reg == 2'h3) begin
            bus.sclOutEn <= 1'b0;
            state_reg <= wiper_eeprom_pkg::HBITS;
          end
        end
        wiper_eeprom_pkg::HBITS: if (tick) begin
          // Data only changes while clock is low
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'h0) begin
            bus.sdaHostOutEn <= tx_reg[8];
          end
          if (phase_reg == 2'h1) bus.sclOutEn <= 1'b1;
          if (phase_reg == 2'h2) rx_reg <= {rx_reg[7:0], bus.sda};
          if (phase_reg == 2'h3) begin
            bus.sclOutEn <= 1'b0;
            tx_reg <= {tx_reg[7:0], 1'b1};
            bitIdx_reg <= bitIdx_reg + 4'h1;
            if (bitIdx_reg == 4'h8) begin
              rxBits <= rx_reg;
              rxValid <= 1'b1;
              state_reg <= stopAfter_reg ? wiper_eeprom_pkg::HSTOP
                                         : wiper_eeprom_pkg::HIDLE;
              cmdReady <= !stopAfter_reg;
            end
          end
        end
        wiper_eeprom_pkg::HSTOP: if (tick) begin
          // Pull data low, raise clock, release data under high clock
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'h0) bus.sdaHostOutEn <= 1'b0;
          if (phase_reg == 2'h1) bus.sclOutEn <= 1'b1;
          if (phase_reg == 2'h2) bus.sdaHostOutEn <= 1'b1;
          if (phase_reg == 2'h3) begin
            state_reg <= wiper_eeprom_pkg::HIDLE;
            cmdReady <= 1'b1;
          end
        end
        default: state_reg <= wiper_eeprom_pkg::HIDLE;
      endcase
    end
  end
endmodule

//--- verification/two_wire_eeprom_wiper_slave_asserts.sv
// Concurrent checks on the two-wire link and the device status outputs
`timescale 1ns/1ps
module two_wire_eeprom_wiper_slave_asserts #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaDevOutEn,
  input wire logic writeProtect,
  input wire logic [7:0] wideWiper,
  input wire logic [6:0] firstNarrowWiper,
  input wire logic [6:0] secondNarrowWiper,
  input wire logic busyWriting,
  input wire logic standby
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic sclQ;
  logic sdaQ;
  logic [3:0] stopAge;
  int busyCnt;
  //////////////////////////////////////////////////////////////////////
  // Previous wire levels, to spot a stop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) {sclQ, sdaQ} <= 2'b11;
    else {sclQ, sdaQ} <= {scl, sda};
  end
  // Cycles since a stop; saturates so an old stop never looks new
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) stopAge <= 4'hF;
    else if (scl && sclQ && sda && !sdaQ) stopAge <= 4'h0;
    else if (stopAge != 4'hF) stopAge <= stopAge + 4'h1;
  end
  // Length of the running timed write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) busyCnt <= 0;
    else if (busyWriting) busyCnt <= busyCnt + 1;
    else busyCnt <= 0;
  end
  //////////////////////////////////////////////////////////////////////
  // Device moves data only while the clock is low
  property p_devEdge; $changed(sdaDevOutEn) |-> !scl; endproperty
  a_devEdge: assert property (p_devEdge)
    else $error("device moved sda with scl high");
  // Bus ignored while the timed write runs
  property p_busyQuiet; busyWriting |-> sdaDevOutEn; endproperty
  a_busyQuiet: assert property (p_busyQuiet)
    else $error("device drove sda while busy");
  property p_busyNotIdle; busyWriting |-> !standby; endproperty
  a_busyNotIdle: assert property (p_busyNotIdle)
    else $error("standby during timed write");
  // Timed write starts only just after a stop
  property p_busyAfterStop; $rose(busyWriting) |-> stopAge < 4'h8;
  endproperty
  a_busyAfterStop: assert property (p_busyAfterStop)
    else $error("timed write without stop");
  // Timed write lasts its full count, one cycle of slack
  property p_busyMin; $fell(busyWriting) |-> busyCnt >= WRITE_CYCLES - 1;
  endproperty
  a_busyMin: assert property (p_busyMin)
    else $error("timed write too short");
  property p_busyMax; busyWriting |-> busyCnt <= WRITE_CYCLES + 1;
  endproperty
  a_busyMax: assert property (p_busyMax)
    else $error("timed write too long");
  // Wipers move only on an unprotected commit
  property p_wiperCommit;
    ($changed(wideWiper) || $changed(firstNarrowWiper) ||
     $changed(secondNarrowWiper)) && $past(reset_n, 2) |->
      (busyWriting || $past(busyWriting)) && !writeProtect;
  endproperty
  a_wiperCommit: assert property (p_wiperCommit)
    else $error("wiper changed outside a commit");
  property p_idleAfter; $fell(busyWriting) |-> ##[0:4] standby; endproperty
  a_idleAfter: assert property (p_idleAfter)
    else $error("no standby after timed write");
  property p_resetIdle; $rose(reset_n) |-> standby; endproperty
  a_resetIdle: assert property (p_resetIdle)
    else $error("no standby after reset");
  property p_idleQuiet; standby |-> sdaDevOutEn; endproperty
  a_idleQuiet: assert property (p_idleQuiet)
    else $error("device drove sda in standby");
endmodule

//--- verification/two_wire_eeprom_wiper_slave_tb.sv
// Self-checking bench: master end talks to device end over the carrier
`timescale 1ns/1ps
`include "wiper_eeprom_map.svh"
module two_wire_eeprom_wiper_slave_tb;
  localparam int WCYC = 400;
  localparam logic [8:0] DEVW = {`DEV_CODE, 1'b1, 1'b0, 1'b1};
  localparam logic [8:0] DEVR = {`DEV_CODE, 1'b1, 1'b1, 1'b1};
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] w;} row_t;
  row_t rows [6] = '{'{8'hF8, 8'h5A, 8'h5A}, '{8'hF9, 8'hE3, 8'h63},
    '{8'hFA, 8'h7F, 8'h7F}, '{8'hFA, 8'h80, 8'h00},
    '{8'h00, 8'hC3, 8'hC3}, '{8'hF7, 8'h96, 8'h96}};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic selectPin = 1'b1;
  logic writeProtect = 1'b0;
  logic cmdValid = 1'b0, cmdStart = 1'b0, cmdStop = 1'b0;
  logic [8:0] cmdBits = 9'h1FF;
  logic cmdReady, rxValid, busyWriting, standby;
  logic [8:0] rxBits, rx;
  logic [7:0] wideWiper;
  logic [6:0] firstNarrowWiper, secondNarrowWiper;
  logic [7:0] pg [4];
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  //////////////////////////////////////////////////////////////////////
  // Clock, ends joined by the carrier, checker beside it
  always #4 sys_clk = ~sys_clk;
  two_wire_if two_wire_if_inst ();
  two_wire_eeprom_wiper_slave #(.WRITE_CYCLES(WCYC))
    two_wire_eeprom_wiper_slave_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus(two_wire_if_inst), .device_select_pin(selectPin),
    .writeProtect(writeProtect), .wideWiper(wideWiper),
    .firstNarrowWiper(firstNarrowWiper),
    .secondNarrowWiper(secondNarrowWiper), .busyWriting(busyWriting),
    .standby(standby));
  two_wire_master #(.HALF_CYCLES(16'h0004)) two_wire_master_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus(two_wire_if_inst),
    .cmdValid(cmdValid), .cmdStart(cmdStart), .cmdStop(cmdStop),
    .cmdBits(cmdBits), .cmdReady(cmdReady), .rxBits(rxBits),
    .rxValid(rxValid));
  two_wire_eeprom_wiper_slave_asserts #(.WRITE_CYCLES(WCYC))
    two_wire_eeprom_wiper_slave_asserts_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .scl(two_wire_if_inst.scl),
    .sda(two_wire_if_inst.sda), .sdaDevOutEn(two_wire_if_inst.sdaDevOutEn),
    .writeProtect(writeProtect), .wideWiper(wideWiper),
    .firstNarrowWiper(firstNarrowWiper),
    .secondNarrowWiper(secondNarrowWiper), .busyWriting(busyWriting),
    .standby(standby));
  //////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input string n, input logic [8:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      print_verdict();
    end
  end
  // One master command; held until taken, result kept in rx
  task automatic cmd(input logic st, sp, input logic [8:0] b);
    @(negedge sys_clk);
    while (cmdReady !== 1'b1) @(negedge sys_clk);
    {cmdStart, cmdStop, cmdBits, cmdValid} = {st, sp, b, 1'b1};
    @(negedge sys_clk);
    cmdValid = 1'b0;
    while (rxValid !== 1'b1) @(negedge sys_clk);
    rx = rxBits;
  endtask
  // Address phase then n bytes of pg; stop on the last one if sp
  task automatic wr(input logic [7:0] a, input int n, input logic sp);
    cmd(1'b1, 1'b0, DEVW);
    chk("devAck", 9'(rx[0]), 9'h000);
    cmd(1'b0, 1'b0, {a, 1'b1});
    chk("addrAck", 9'(rx[0]), 9'h000);
    for (int i = 0; i < n; i++) begin
      cmd(1'b0, sp && i == n - 1, {pg[i], 1'b1});
      chk("dataAck", 9'(rx[0]), 9'h000);
    end
  endtask
  // Bus done; timed write (if known) runs out, then standby
  task automatic fin(input logic busyExp);
    @(negedge sys_clk);
    while (cmdReady !== 1'b1) @(negedge sys_clk);
    repeat (8) @(negedge sys_clk);
    if (busyExp !== 1'bx) chk("busy", 9'(busyWriting), 9'(busyExp));
    while (busyWriting !== 1'b0) @(negedge sys_clk);
    // Standby is registered, so it follows one cycle later
    @(negedge sys_clk);
    chk("standby", 9'(standby), 9'h001);
  endtask
  // Random read of one byte, or two when n is 2
  task automatic rd(input logic [7:0] a, d0, input int n,
                    input logic [7:0] d1);
    wr(a, 0, 1'b0);
    cmd(1'b1, 1'b0, DEVR);
    chk("readAck", 9'(rx[0]), 9'h000);
    cmd(1'b0, n == 1, {8'hFF, n == 1});
    chk("rdata", 9'(rx[8:1]), 9'(d0));
    if (n == 2) begin
      cmd(1'b0, 1'b1, 9'h1FF);
      chk("rnext", 9'(rx[8:1]), 9'(d1));
    end
    fin(1'b0);
  endtask
  function automatic logic [8:0] wiper(input logic [7:0] a);
    if (a == 8'hF8) return 9'(wideWiper);
    if (a == 8'hF9) return 9'(firstNarrowWiper);
    return 9'(secondNarrowWiper);
  endfunction
  //////////////////////////////////////////////////////////////////////
  // Table of byte writes, then the awkward cases
  initial begin
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      pg[0] = rows[i].d;
      wr(rows[i].a, 1, 1'b1);
      fin(1'b1);
      if (rows[i].a >= 8'hF8) begin
        chk("wiper", wiper(rows[i].a), 9'(rows[i].w));
      end
      rd(rows[i].a, rows[i].d, 1, 8'h00);
    end
    // Select bit against the pin: ignored
    cmd(1'b1, 1'b0, {`DEV_CODE, 1'b0, 1'b0, 1'b1});
    chk("selNack", 9'(rx[0]), 9'h001);
    cmd(1'b0, 1'b1, 9'h1FF);
    fin(1'b0);
    // Pin moved low: the same select bit now matches
    selectPin = 1'b0;
    cmd(1'b1, 1'b0, {`DEV_CODE, 1'b0, 1'b0, 1'b1});
    chk("selAck", 9'(rx[0]), 9'h000);
    cmd(1'b0, 1'b1, 9'h1FF);
    fin(1'b0);
    selectPin = 1'b1;
    // Page write from FEh wraps to F8h; poll while it commits
    pg = '{8'h11, 8'h22, 8'h33, 8'h44};
    wr(8'hFE, 4, 1'b1);
    cmd(1'b1, 1'b0, DEVW);
    chk("pollNack", 9'(rx[0]), 9'h001);
    cmd(1'b0, 1'b1, 9'h1FF);
    fin(1'bx);
    chk("wrapWide", 9'(wideWiper), 9'h033);
    chk("wrapFirst", 9'(firstNarrowWiper), 9'h044);
    rd(8'hFF, 8'h22, 2, 8'hC3);
    // Aligned page start keeps bytes in sequence
    wr(8'hE0, 4, 1'b1);
    fin(1'b1);
    rd(8'hE2, 8'h33, 2, 8'h44);
    // Protected write changes nothing
    writeProtect = 1'b1;
    pg[0] = 8'hEE;
    wr(8'hF8, 1, 1'b1);
    fin(1'b0);
    writeProtect = 1'b0;
    chk("protect", 9'(wideWiper), 9'h033);
    rd(8'hF8, 8'h33, 1, 8'h00);
    // Write cut by a repeated start is dropped
    pg[0] = 8'h55;
    wr(8'hF9, 1, 1'b0);
    cmd(1'b1, 1'b0, DEVR);
    chk("curAck", 9'(rx[0]), 9'h000);
    cmd(1'b0, 1'b1, 9'h1FF);
    chk("curAddr", 9'(rx[8:1]), 9'h080);
    fin(1'b0);
    chk("discard", 9'(firstNarrowWiper), 9'h044);
    // Second reset in mid-run
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("rstIdle", 9'(standby), 9'h001);
    chk("rstBusy", 9'(busyWriting), 9'h000);
    reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("keepWide", 9'(wideWiper), 9'h033);
    // Recovery: nine clocks with data released, then a fresh start
    cmd(1'b0, 1'b0, 9'h1FF);
    chk("recover", rx, 9'h1FF);
    rd(8'hF8, 8'h33, 1, 8'h00);
    print_verdict();
  end
endmodule
